// [core/dcc_defs.svh]
// Register map, field positions, reset values and timing counts for comparator control
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register indices; byte address is four times the index
`define DCC_CTRL_IDX 8'h1F
`define DCC_STAT_IDX 8'h20
`define DCC_MASK_IDX 8'h21

// Control register fields
`define DCC_C2_RES_BIT 7
`define DCC_C1_RES_BIT 6
`define DCC_CIS_BIT 3
`define DCC_MODE_MSB 2
`define DCC_MODE_LSB 0

// Reset values
`define DCC_CTRL_RST 8'h00
`define DCC_STAT_RST 3'h0
`define DCC_MASK_RST 3'h0

// Event bits in status and mask
`define DCC_EV_C1 0
`define DCC_EV_C2 1
`define DCC_EV_SETTLE 2
`define DCC_EV_W 3

// Timing: settle time is a least wait, so the cycle count rounds up
`define DCC_CLK_NS 20
`define DCC_SETTLE_NS 10000
`define DCC_SETTLE_CYC ((`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)
`define DCC_CNT_W 10

`endif

// [core/dcc_pkg.sv]
// Types shared by the comparator control block
`include "dcc_defs.svh"

package dcc_pkg;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_SETTLE = 2'h1
    } dcc_state_type;

    typedef enum logic [2:0] {
        MODE_RESET = 3'h0,
        MODE_THREE_MUX = 3'h1,
        MODE_FOUR_MUX = 3'h2,
        MODE_COMMON_REF = 3'h3,
        MODE_INDEP = 3'h4,
        MODE_ONE_INDEP = 3'h5,
        MODE_COMMON_OUT = 3'h6,
        MODE_OFF = 3'h7
    } dcc_mode_type;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_PIN0 = 3'h1,
        SEL_PIN1 = 3'h2,
        SEL_PIN2 = 3'h3,
        SEL_PIN3 = 3'h4,
        SEL_VREF = 3'h5
    } dcc_sel_type;

    typedef struct packed {
        logic en;
        dcc_sel_type inv_sel;
        dcc_sel_type pos_sel;
    } dcc_comp_route_type;

    typedef struct packed {
        dcc_comp_route_type c2;
        dcc_comp_route_type c1;
        logic [3:0] analog_en;
        logic vref_en;
    } dcc_route_type;

    typedef logic [`DCC_CNT_W-1:0] dcc_cnt_type;
    typedef logic [`DCC_EV_W-1:0] dcc_ev_type;

endpackage : dcc_pkg

// [core/dcc_route.sv]
// Mode decoder: comparator enables and input switch settings for each mode
`timescale 1ns/100ps

module dcc_route (
    // Mode selection
    input wire dcc_pkg::dcc_mode_type mode,
    input wire logic comp_input_switch,
    // Switch settings
    output dcc_pkg::dcc_route_type route
);

    function automatic dcc_pkg::dcc_comp_route_type comp(
        input logic en,
        input dcc_pkg::dcc_sel_type inv,
        input dcc_pkg::dcc_sel_type pos
    );
        comp.en = en;
        comp.inv_sel = en ? inv : dcc_pkg::SEL_NONE;
        comp.pos_sel = en ? pos : dcc_pkg::SEL_NONE;
    endfunction : comp

    wire dcc_pkg::dcc_sel_type c1_mux_inv = comp_input_switch ? dcc_pkg::SEL_PIN3 : dcc_pkg::SEL_PIN0; // RL4 RL5
    wire dcc_pkg::dcc_sel_type c2_mux_inv = comp_input_switch ? dcc_pkg::SEL_PIN2 : dcc_pkg::SEL_PIN1; // RL5

    function automatic dcc_pkg::dcc_route_type route_of(
        input dcc_pkg::dcc_mode_type m,
        input dcc_pkg::dcc_sel_type inv1,
        input dcc_pkg::dcc_sel_type inv2
    );
        route_of.vref_en = 1'b0;
        case (m) // RL6 RL10
            dcc_pkg::MODE_THREE_MUX: begin
                route_of.c1 = comp(1'b1, inv1, dcc_pkg::SEL_PIN2); // RL4
                route_of.c2 = comp(1'b1, dcc_pkg::SEL_PIN1, dcc_pkg::SEL_PIN2);
                route_of.analog_en = 4'hF;
            end
            dcc_pkg::MODE_FOUR_MUX: begin
                route_of.c1 = comp(1'b1, inv1, dcc_pkg::SEL_VREF); // RL5
                route_of.c2 = comp(1'b1, inv2, dcc_pkg::SEL_VREF); // RL5
                route_of.analog_en = 4'hF;
                route_of.vref_en = 1'b1;
            end
            dcc_pkg::MODE_COMMON_REF, dcc_pkg::MODE_COMMON_OUT: begin
                route_of.c1 = comp(1'b1, dcc_pkg::SEL_PIN0, dcc_pkg::SEL_PIN2);
                route_of.c2 = comp(1'b1, dcc_pkg::SEL_PIN1, dcc_pkg::SEL_PIN2);
                route_of.analog_en = 4'h7;
            end
            dcc_pkg::MODE_INDEP: begin
                route_of.c1 = comp(1'b1, dcc_pkg::SEL_PIN0, dcc_pkg::SEL_PIN3);
                route_of.c2 = comp(1'b1, dcc_pkg::SEL_PIN1, dcc_pkg::SEL_PIN2);
                route_of.analog_en = 4'hF;
            end
            dcc_pkg::MODE_ONE_INDEP: begin
                route_of.c1 = comp(1'b0, dcc_pkg::SEL_NONE, dcc_pkg::SEL_NONE);
                route_of.c2 = comp(1'b1, dcc_pkg::SEL_PIN1, dcc_pkg::SEL_PIN2);
                route_of.analog_en = 4'h6;
            end
            dcc_pkg::MODE_OFF: begin
                route_of.c1 = comp(1'b0, dcc_pkg::SEL_NONE, dcc_pkg::SEL_NONE);
                route_of.c2 = comp(1'b0, dcc_pkg::SEL_NONE, dcc_pkg::SEL_NONE);
                route_of.analog_en = 4'h0;
            end
            default: begin
                // Reset mode: comparators off, pins parked as analog to avoid leakage
                route_of.c1 = comp(1'b0, dcc_pkg::SEL_NONE, dcc_pkg::SEL_NONE);
                route_of.c2 = comp(1'b0, dcc_pkg::SEL_NONE, dcc_pkg::SEL_NONE);
                route_of.analog_en = 4'hF;
            end
        endcase
    endfunction : route_of

    assign route = route_of(mode, c1_mux_inv, c2_mux_inv);

endmodule : dcc_route

// [core/dcc_top.sv]
// Comparator control block: APB registers, mode routing, result capture and interrupt
`timescale 1ns/100ps
`include "dcc_defs.svh"

// Functional notes
// RL1: Bit 7 reads comparator 2 result
// RL2: Bit 6 reads comparator 1 result
// RL3: Bits 5 and 4 always read zero
// RL4: Mode 001: switch picks pin 3 or 0
// RL5: Mode 010: switch picks pins 3/2 or 0/1
// RL6: Three-bit mode field selects eight configurations; modes 011 and 110 route the same here
// RL7: Results invalid for settle delay after change
// RL8: Software masks interrupts around mode changes
// RL9: Port A direction register sets pin direction
// RL10: Inputs from pins 0-3 and voltage reference
// RL11: Only switch and mode writable; reset clears
module dcc_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Analog comparator outputs, asynchronous
    input wire logic COMP1_RAW,
    input wire logic COMP2_RAW,
    // Port A direction, 1 = input
    input wire logic [3:0] PORT_A_DIR,
    // Analog switch control
    output dcc_pkg::dcc_route_type ROUTE,
    // Pin output enables
    output logic [3:0] PIN_OE,
    // Status
    output logic RESULT_VALID,
    output logic IRQ
);

    function automatic logic [7:0] addr_of(input logic [7:0] idx);
        addr_of = {idx[5:0], 2'b00};
    endfunction : addr_of

    localparam logic [7:0] ADDR_CTRL = addr_of(`DCC_CTRL_IDX);
    localparam logic [7:0] ADDR_STAT = addr_of(`DCC_STAT_IDX);
    localparam logic [7:0] ADDR_MASK = addr_of(`DCC_MASK_IDX);
    localparam dcc_pkg::dcc_cnt_type SETTLE_LAST =
        dcc_pkg::dcc_cnt_type'(`DCC_SETTLE_CYC - 1);

    // Register state
    logic cis_ff;
    dcc_pkg::dcc_mode_type mode_ff;
    dcc_pkg::dcc_ev_type stat_ff;
    dcc_pkg::dcc_ev_type mask_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    dcc_pkg::dcc_route_type route_ff;
    logic [3:0] pin_oe_ff;

    // Settle tracking
    dcc_pkg::dcc_state_type state_ff;
    dcc_pkg::dcc_state_type nxt_state;
    dcc_pkg::dcc_cnt_type cnt_ff;
    dcc_pkg::dcc_cnt_type nxt_cnt;

    // Comparator sampling
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] result_ff;
    logic [1:0] comp_en;
    logic [1:0] ev_change;

    // Bus decode
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_any;
    logic [31:0] rd_word;

    wire setup_phase = PSEL & ~PENABLE;
    wire access_phase = PSEL & PENABLE;
    wire wr_commit = access_phase & PWRITE & PSTRB[0];
    wire wr_ctrl = wr_commit & hit_ctrl;
    wire wr_stat = wr_commit & hit_stat;
    wire wr_mask = wr_commit & hit_mask;

    wire dcc_pkg::dcc_mode_type wr_mode =
        dcc_pkg::dcc_mode_type'(PWDATA[`DCC_MODE_MSB:`DCC_MODE_LSB]);
    wire mode_change = wr_ctrl & (wr_mode != mode_ff);
    wire settle_done = (state_ff == dcc_pkg::ST_SETTLE) & (cnt_ff == '0) & ~mode_change;
    wire in_run = (state_ff == dcc_pkg::ST_RUN);

    dcc_pkg::dcc_route_type nxt_route;

    // Address decode; unmapped addresses answer with an error
    always_comb begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        if (PADDR == ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (PADDR == ADDR_STAT) begin
            hit_stat = 1'b1;
        end else if (PADDR == ADDR_MASK) begin
            hit_mask = 1'b1;
        end
    end

    assign hit_any = hit_ctrl | hit_stat | hit_mask;

    // Zero wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = access_phase & ~hit_any;

    // Read word; bits above the register width read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_word[`DCC_C2_RES_BIT] = result_ff[1]; // RL1
            rd_word[`DCC_C1_RES_BIT] = result_ff[0]; // RL2
            rd_word[5:4] = 2'b00; // RL3
            rd_word[`DCC_CIS_BIT] = cis_ff;
            rd_word[`DCC_MODE_MSB:`DCC_MODE_LSB] = mode_ff;
        end else if (hit_stat) begin
            rd_word[`DCC_EV_W-1:0] = stat_ff;
        end else if (hit_mask) begin
            rd_word[`DCC_EV_W-1:0] = mask_ff;
        end
    end

    // Read data is captured in the setup cycle and held through the access
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_phase & ~PWRITE) begin
            prdata_ff <= rd_word;
        end
    end

    assign PRDATA = prdata_ff;

    // Control register: result and unused bits ignore writes
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cis_ff <= 1'(`DCC_CTRL_RST >> `DCC_CIS_BIT); // RL11
            mode_ff <= dcc_pkg::MODE_RESET; // RL11
        end else if (wr_ctrl) begin
            cis_ff <= PWDATA[`DCC_CIS_BIT]; // RL11
            mode_ff <= wr_mode; // RL6
        end
    end

    // Mode decoder
    dcc_route u_route (
        .mode (mode_ff),
        .comp_input_switch (cis_ff),
        .route (nxt_route)
    );

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            route_ff <= '0;
        end else begin
            route_ff <= nxt_route; // RL10
        end
    end

    assign ROUTE = route_ff;
    assign comp_en = {route_ff.c2.en, route_ff.c1.en};

    // Pin direction follows the port A direction register in every mode
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pin_oe_ff <= 4'h0;
        end else begin
            pin_oe_ff <= ~PORT_A_DIR; // RL9
        end
    end

    assign PIN_OE = pin_oe_ff;

    // Settle timer: a new mode write restarts the full wait
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            dcc_pkg::ST_RUN: begin
                if (mode_change) begin
                    nxt_state = dcc_pkg::ST_SETTLE; // RL7
                    nxt_cnt = SETTLE_LAST; // RL7
                end
            end
            dcc_pkg::ST_SETTLE: begin
                if (mode_change) begin
                    nxt_cnt = SETTLE_LAST; // RL7
                end else if (cnt_ff == '0) begin
                    nxt_state = dcc_pkg::ST_RUN;
                end else begin
                    nxt_cnt = cnt_ff - dcc_pkg::dcc_cnt_type'(1);
                end
            end
            default: begin
                nxt_state = dcc_pkg::ST_RUN;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_ff <= dcc_pkg::ST_RUN;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign RESULT_VALID = in_run;

    // Comparator outputs: synchronise, then capture per comparator
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_comp
            wire raw_in = (gi == 0) ? COMP1_RAW : COMP2_RAW;

            always_ff @(posedge CLK_SYS or negedge RESETN) begin
                if (!RESETN) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= raw_in;
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end

            // A change only counts while the mode has settled, so a mode
            // switch never raises a false change event
            assign ev_change[gi] = in_run & comp_en[gi] & (sync2_ff[gi] != result_ff[gi]); // RL7

            // Disabled comparators read zero; during settling the last
            // valid level is held and the new level is taken silently
            always_ff @(posedge CLK_SYS or negedge RESETN) begin
                if (!RESETN) begin
                    result_ff[gi] <= 1'b0;
                end else if (!comp_en[gi]) begin
                    result_ff[gi] <= 1'b0;
                end else if (in_run | settle_done) begin
                    result_ff[gi] <= sync2_ff[gi]; // RL1 RL2 RL7
                end
            end
        end
    endgenerate

    // Interrupt status: sticky, write one to clear, a new event wins
    wire dcc_pkg::dcc_ev_type ev_set = {settle_done, ev_change[1], ev_change[0]};
    wire dcc_pkg::dcc_ev_type ev_clr = wr_stat ? PWDATA[`DCC_EV_W-1:0] : '0;
    wire dcc_pkg::dcc_ev_type nxt_stat = (stat_ff & ~ev_clr) | ev_set;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            stat_ff <= `DCC_STAT_RST;
            mask_ff <= `DCC_MASK_RST;
        end else begin
            stat_ff <= nxt_stat;
            if (wr_mask) begin
                mask_ff <= PWDATA[`DCC_EV_W-1:0];
            end
        end
    end

    // Interrupt line follows status one cycle later; masking before a mode
    // write keeps an in-flight change from asserting it
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff); // RL8
        end
    end

    assign IRQ = irq_ff;

endmodule : dcc_top

// [sim/dcc_top_assertions.sv]
// Port checker for the comparator control block
`timescale 1ns/100ps
`include "dcc_defs.svh"

module dcc_top_assertions (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Pins and status
    input wire logic [3:0] PORT_A_DIR,
    input wire dcc_pkg::dcc_route_type ROUTE,
    input wire logic [3:0] PIN_OE,
    input wire logic RESULT_VALID
);
    localparam int SETTLE = `DCC_SETTLE_CYC;
    localparam logic [7:0] A_CTRL = 8'(`DCC_CTRL_IDX * 4);
    logic [3:0] ctrl_ff;
    logic [1:0] age_ff;
    logic [15:0] low_ff;
    wire acc = PSEL && PENABLE;
    wire mapped = (PADDR == A_CTRL) || (PADDR == 8'h80) || (PADDR == 8'h84);
    wire ctrl_wr = acc && PWRITE && PSTRB[0] && (PADDR == A_CTRL);
    wire new_mode = ctrl_wr && (PWDATA[2:0] != ctrl_ff[2:0]);
    // Counts settle samples and the age of the last control write that changed mode or switch, for route timing
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_ff <= 4'h0;
            age_ff <= 2'h0;
            low_ff <= 16'h0;
        end else begin
            ctrl_ff <= ctrl_wr ? PWDATA[3:0] : ctrl_ff;
            age_ff <= (ctrl_wr && PWDATA[3:0] != ctrl_ff) ? 2'h0 : age_ff + {1'b0, age_ff != 2'h3};
            low_ff <= (new_mode || RESULT_VALID) ? 16'h0 : low_ff + 16'h1;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    sequence ctrl_commit;
        ctrl_wr;
    endsequence
    sequence mode_change;
        ctrl_commit ##0 (PWDATA[2:0] != ctrl_ff[2:0]);
    endsequence
    chk_ready_high: assert property (acc |-> PREADY) else $error("pready low in access");
    chk_err_unmapped: assert property (acc && !mapped |-> PSLVERR) else $error("no error");
    chk_err_mapped: assert property (acc && mapped |-> !PSLVERR) else $error("false error");
    chk_ctrl_zeros: assert property (acc && !PWRITE && PADDR == A_CTRL |->
        PRDATA[31:8] == 24'h0 && PRDATA[5:4] == 2'h0) else $error("unused bits set");
    chk_mode_settle: assert property (mode_change |=> !RESULT_VALID [*8])
        else $error("valid during settle");
    chk_settle_len: assert property ($rose(RESULT_VALID) |-> low_ff == SETTLE)
        else $error("settle length wrong");
    chk_pin_dir: assert property ($past(RESETN) |-> PIN_OE == ~$past(PORT_A_DIR))
        else $error("pin enable not from direction");
    chk_switch_one: assert property (age_ff == 2'h3 && ctrl_ff[2:0] == 3'h1 |->
        ROUTE.c1.inv_sel == (ctrl_ff[3] ? dcc_pkg::SEL_PIN3 : dcc_pkg::SEL_PIN0))
        else $error("mode one switch wrong");
    chk_switch_two: assert property (age_ff == 2'h3 && ctrl_ff[2:0] == 3'h2 |->
        ROUTE.c1.inv_sel == (ctrl_ff[3] ? dcc_pkg::SEL_PIN3 : dcc_pkg::SEL_PIN0) &&
        ROUTE.c2.inv_sel == (ctrl_ff[3] ? dcc_pkg::SEL_PIN2 : dcc_pkg::SEL_PIN1))
        else $error("mode two switch wrong");
    chk_mode_off: assert property (age_ff == 2'h3 && ctrl_ff[1:0] == {2{ctrl_ff[2]}} |->
        !ROUTE.c1.en && !ROUTE.c2.en) else $error("comparator on in off mode");
endmodule : dcc_top_assertions

bind dcc_top dcc_top_assertions i_dcc_top_assertions (.*);

// [sim/dcc_analog_model.sv]
// Analog side model: pin and reference levels feeding both comparators
`timescale 1ns/100ps

module dcc_analog_model (
    // Switch settings
    input wire dcc_pkg::dcc_route_type route,
    // Levels in arbitrary units
    input wire logic [3:0][7:0] pin_lvl,
    input wire logic [7:0] vref_lvl,
    // Comparator outputs
    output logic comp1_raw,
    output logic comp2_raw
);
    logic [7:0] lvl [8];
    always_comb begin
        lvl = '{default: 8'h00};
        lvl[1] = pin_lvl[0];
        lvl[2] = pin_lvl[1];
        lvl[3] = pin_lvl[2];
        lvl[4] = pin_lvl[3];
        lvl[5] = route.vref_en ? vref_lvl : 8'h00;
    end
    // Only strictly greater reads high; a disabled comparator holds low
    assign comp1_raw = route.c1.en && (lvl[route.c1.pos_sel] > lvl[route.c1.inv_sel]);
    assign comp2_raw = route.c2.en && (lvl[route.c2.pos_sel] > lvl[route.c2.inv_sel]);
endmodule : dcc_analog_model

// [sim/testbench.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
`include "dcc_defs.svh"

module testbench;
    localparam logic [7:0] A_CTRL = 8'(`DCC_CTRL_IDX * 4);
    localparam logic [7:0] A_STAT = 8'(`DCC_STAT_IDX * 4);
    localparam logic [7:0] A_MASK = 8'(`DCC_MASK_IDX * 4);
    logic CLK_SYS = 1'b0;
    logic RESETN = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0] PORT_A_DIR = 4'hF;
    logic [3:0] PSTRB = 4'hF;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, COMP1_RAW, COMP2_RAW, RESULT_VALID, IRQ;
    logic [3:0] PIN_OE;
    dcc_pkg::dcc_route_type ROUTE;
    logic [3:0][7:0] pin_lvl = '0;
    logic [7:0] vref_lvl = 8'h00;
    logic [31:0] rd;
    logic err;
    logic [2:0] cur_mode = 3'h0;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    dcc_top i_dcc_top (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .COMP1_RAW(COMP1_RAW), .COMP2_RAW(COMP2_RAW),
        .PORT_A_DIR(PORT_A_DIR), .ROUTE(ROUTE), .PIN_OE(PIN_OE),
        .RESULT_VALID(RESULT_VALID), .IRQ(IRQ));
    dcc_analog_model i_dcc_analog_model (.route(ROUTE), .pin_lvl(pin_lvl),
        .vref_lvl(vref_lvl), .comp1_raw(COMP1_RAW), .comp2_raw(COMP2_RAW));

    initial begin
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    // Eleven settle waits of 500 cycles dominate; the ceiling leaves wide margin
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic set_ctrl(input logic [31:0] v);
        int n = 1;
        apb(1'b1, A_CTRL, v);
        if (v[2:0] != cur_mode) begin
            @(posedge CLK_SYS);
            #1;
            check(RESULT_VALID, 1'b0);
            while (RESULT_VALID !== 1'b1 && n < 600) begin
                @(posedge CLK_SYS);
                #1;
                n = n + 1;
            end
            check(n, `DCC_SETTLE_CYC);
        end else begin
            repeat (4) @(posedge CLK_SYS);
        end
        cur_mode = v[2:0];
    endtask : set_ctrl

    task automatic t_reset;
        rd_chk(A_CTRL, 32'h0);
        rd_chk(A_STAT, 32'h0);
        rd_chk(A_MASK, 32'h0);
        check(err, 1'b0);
        apb(1'b1, 8'h40, 32'hFF);
        check(err, 1'b1);
        rd_chk(8'h40, 32'h0);
        check(err, 1'b1);
        PSTRB <= 4'hE;
        apb(1'b1, A_CTRL, 32'h9);
        PSTRB <= 4'hF;
        rd_chk(A_CTRL, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_dir;
        @(posedge CLK_SYS);
        PORT_A_DIR <= 4'h5;
        repeat (2) @(posedge CLK_SYS);
        #1;
        check(PIN_OE, 4'hA);
        $display("test direction done");
    endtask : t_dir

    task automatic t_modes;
        apb(1'b1, A_MASK, 32'h0);
        set_ctrl(32'hFFFF_FFFF);
        rd_chk(A_CTRL, 32'h0F);
        for (int m = 0; m < 8; m++) begin
            set_ctrl(32'(m) | 32'h8);
            rd_chk(A_CTRL, 32'(m) | 32'h8);
            check(PIN_OE, 4'hA);
        end
        rd_chk(A_STAT, 32'h4);
        $display("test modes done");
    endtask : t_modes

    task automatic t_switch;
        set_ctrl(32'h1);
        check(ROUTE.c1.inv_sel, dcc_pkg::SEL_PIN0);
        set_ctrl(32'h9);
        check(ROUTE.c1.inv_sel, dcc_pkg::SEL_PIN3);
        set_ctrl(32'h2);
        check({ROUTE.c1.inv_sel, ROUTE.c2.inv_sel}, {dcc_pkg::SEL_PIN0, dcc_pkg::SEL_PIN1});
        set_ctrl(32'hA);
        check({ROUTE.c1.inv_sel, ROUTE.c2.inv_sel}, {dcc_pkg::SEL_PIN3, dcc_pkg::SEL_PIN2});
        $display("test switch done");
    endtask : t_switch

    task automatic t_results;
        apb(1'b1, A_STAT, 32'h7);
        rd_chk(A_STAT, 32'h0);
        vref_lvl <= 8'h64;
        pin_lvl[2] <= 8'hC8;
        pin_lvl[3] <= 8'h0A;
        repeat (6) @(posedge CLK_SYS);
        rd_chk(A_CTRL, 32'h4A);
        rd_chk(A_STAT, 32'h1);
        #1;
        check(IRQ, 1'b0);
        apb(1'b1, A_MASK, 32'h1);
        rd_chk(A_MASK, 32'h1);
        #1;
        check(IRQ, 1'b1);
        apb(1'b1, A_STAT, 32'h1);
        rd_chk(A_STAT, 32'h0);
        #1;
        check(IRQ, 1'b0);
        pin_lvl[2] <= 8'h0A;
        pin_lvl[3] <= 8'hC8;
        repeat (6) @(posedge CLK_SYS);
        rd_chk(A_CTRL, 32'h8A);
        rd_chk(A_STAT, 32'h3);
        #1;
        check(IRQ, 1'b1);
        $display("test results done");
    endtask : t_results

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        // Drop from high so the asynchronous reset sees a real falling edge
        RESETN <= 1'b0;
        repeat (20) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        t_reset();
        t_dir();
        t_modes();
        t_switch();
        t_results();
        summarize();
    end
endmodule : testbench
